/* File: sct_pkg.sv */
// Package for the slow clock elapsed timer: register map, field layout,
// reset values and the packed types that carry bus requests and state.
// Assumes a single 20 MHz reference clock and a synchronous active-low reset.
package sct_pkg;

   // Register byte offsets on the plain register port.
   localparam logic [7:0] SCT_OFS_MODE = 8'h00;
   localparam logic [7:0] SCT_OFS_ALARM = 8'h04;
   localparam logic [7:0] SCT_OFS_VALUE = 8'h08;
   localparam logic [7:0] SCT_OFS_STATUS = 8'h0C;

   // Mode register field positions.
   localparam int SCT_MODE_DIV_LSB = 0;
   localparam int SCT_MODE_DIV_MSB = 15;
   localparam int SCT_MODE_ALM_IEN = 16;
   localparam int SCT_MODE_INC_IEN = 17;
   localparam int SCT_MODE_RESTART = 18;
   localparam int SCT_MODE_DISABLE = 20;
   localparam int SCT_MODE_CAL_SEL = 24;

   // Status register field positions.
   localparam int SCT_STAT_ALARM = 0;
   localparam int SCT_STAT_INC = 1;

   // Reset values.
   localparam logic [15:0] SCT_DIV_RESET = 16'h8000;
   localparam logic [31:0] SCT_ALARM_RESET = 32'hFFFFFFFF;
   localparam logic [31:0] SCT_COUNT_RESET = 32'h00000000;
   localparam logic [15:0] SCT_PRESC_RESET = 16'h0000;

   // Slow clock edges between a status read and the interrupt returning.
   localparam logic [1:0] SCT_IRQ_HOLD_EDGES = 2'h2;

   // One register port request, as issued by the bus master.
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } sct_bus_req_s;

   // Three-stage input synchroniser plus the accepted stable level.
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } sct_sync_s;

   // Complete state of the timer.
   typedef struct packed {
      sct_sync_s slow_sync;
      sct_sync_s cal_sync;
      logic [15:0] divisor;
      logic alarm_irq_enable;
      logic increment_irq_enable;
      logic timer_disable;
      logic calendar_second_select;
      logic [31:0] alarm_value;
      logic [15:0] prescaler;
      logic [31:0] counter_value;
      logic increment_flag;
      logic alarm_flag;
      logic match_prev;
      logic [1:0] irq_hold;
      logic [31:0] rdata;
   } sct_state_s;

endpackage

/* File: sct_timer.sv */
// Slow clock elapsed timer: prescaler, 32-bit counter, alarm compare,
// clear-on-read flags and an interrupt line, behind a plain register port.
// Assumes the slow clock and calendar tick arrive as pins asynchronous to
// ref_clk and that both are far slower than ref_clk.
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps

module sct_timer
   import sct_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic resetn,
   // Register port.
   input wire sct_bus_req_s bus_req,
   output logic [31:0] rdata,
   // Slow time sources.
   input wire logic slow_clock,
   input wire logic calendar_tick,
   // Event outputs.
   output logic irq,
   output logic alarm_out
);

   sct_state_s st_reg;
   sct_state_s st_next;

   // Decoded accesses and counting events, all combinational.
   logic wr_mode;
   logic wr_alarm;
   logic rd_mode;
   logic rd_alarm;
   logic rd_value;
   logic rd_status;
   logic slow_rise;
   logic cal_rise;
   logic run;
   logic rollover;
   logic count_step;
   logic match_now;
   logic restart;

   // Address decoding for writes and reads.
   always_comb begin
      wr_mode = 1'b0;
      wr_alarm = 1'b0;
      rd_mode = 1'b0;
      rd_alarm = 1'b0;
      rd_value = 1'b0;
      rd_status = 1'b0;
      if (bus_req.addr == SCT_OFS_MODE) begin
         wr_mode = bus_req.wr;
         rd_mode = bus_req.rd;
      end else if (bus_req.addr == SCT_OFS_ALARM) begin
         wr_alarm = bus_req.wr;
         rd_alarm = bus_req.rd;
      end else if (bus_req.addr == SCT_OFS_VALUE) begin
         rd_value = bus_req.rd;
      end else if (bus_req.addr == SCT_OFS_STATUS) begin
         rd_status = bus_req.rd;
      end
   end

   // Edge detection on the synchronised inputs and the counting events.
   always_comb begin
      slow_rise = (st_reg.slow_sync.s2 == st_reg.slow_sync.s3) &&
                  st_reg.slow_sync.s3 && !st_reg.slow_sync.level;
      cal_rise = (st_reg.cal_sync.s2 == st_reg.cal_sync.s3) &&
                 st_reg.cal_sync.s3 && !st_reg.cal_sync.level;
      run = !st_reg.timer_disable;
      restart = wr_mode && bus_req.wdata[SCT_MODE_RESTART];
      // period is divisor, zero gives 65536
      rollover = run && slow_rise &&
                 (st_reg.prescaler == 16'(st_reg.divisor - 16'h0001));
      count_step = st_reg.calendar_second_select ? (run && cal_rise) : rollover;
      match_now = (st_reg.counter_value == st_reg.alarm_value);
   end

   // Next-state computation for the whole block.
   always_comb begin
      st_next = st_reg;

      // Synchroniser chains; the first stage feeds only the second.
      st_next.slow_sync.s1 = slow_clock;
      st_next.slow_sync.s2 = st_reg.slow_sync.s1;
      st_next.slow_sync.s3 = st_reg.slow_sync.s2;
      if (st_reg.slow_sync.s2 == st_reg.slow_sync.s3) begin
         st_next.slow_sync.level = st_reg.slow_sync.s3;
      end
      st_next.cal_sync.s1 = calendar_tick;
      st_next.cal_sync.s2 = st_reg.cal_sync.s1;
      st_next.cal_sync.s3 = st_reg.cal_sync.s2;
      if (st_reg.cal_sync.s2 == st_reg.cal_sync.s3) begin
         st_next.cal_sync.level = st_reg.cal_sync.s3;
      end

      // Mode and alarm register writes.
      if (wr_mode) begin
         st_next.divisor = bus_req.wdata[SCT_MODE_DIV_MSB:SCT_MODE_DIV_LSB];
         st_next.alarm_irq_enable = bus_req.wdata[SCT_MODE_ALM_IEN];
         st_next.increment_irq_enable = bus_req.wdata[SCT_MODE_INC_IEN];
         st_next.timer_disable = bus_req.wdata[SCT_MODE_DISABLE];
         st_next.calendar_second_select = bus_req.wdata[SCT_MODE_CAL_SEL];
      end
      if (wr_alarm) begin
         st_next.alarm_value = bus_req.wdata;
      end

      // Prescaler: counts slow clock edges and wraps at the period.
      if (rollover) begin
         st_next.prescaler = SCT_PRESC_RESET;
      end else if (run && slow_rise) begin
         st_next.prescaler = 16'(st_reg.prescaler + 16'h0001);
      end

      if (count_step) begin
         st_next.counter_value = 32'(st_reg.counter_value + 32'h00000001);
      end

      if (restart) begin
         st_next.prescaler = SCT_PRESC_RESET;
         st_next.counter_value = SCT_COUNT_RESET;
      end

      // Alarm match is taken on its rising edge so a read can clear it.
      st_next.match_prev = match_now;

      if (rd_status) begin
         st_next.increment_flag = 1'b0;
         st_next.alarm_flag = 1'b0;
      end
      if (rollover) begin
         st_next.increment_flag = 1'b1;
      end
      if (match_now && !st_reg.match_prev) begin
         st_next.alarm_flag = 1'b1;
      end

      if (rd_status) begin
         st_next.irq_hold = SCT_IRQ_HOLD_EDGES;
      end else if (slow_rise && st_reg.irq_hold != 2'h0) begin
         st_next.irq_hold = 2'(st_reg.irq_hold - 2'h1);
      end

      // Read data stands only in the cycle after the read strobe.
      st_next.rdata = 32'h00000000;
      if (rd_mode) begin
         st_next.rdata[SCT_MODE_DIV_MSB:SCT_MODE_DIV_LSB] = st_reg.divisor;
         st_next.rdata[SCT_MODE_ALM_IEN] = st_reg.alarm_irq_enable;
         st_next.rdata[SCT_MODE_INC_IEN] = st_reg.increment_irq_enable;
         st_next.rdata[SCT_MODE_DISABLE] = st_reg.timer_disable;
         st_next.rdata[SCT_MODE_CAL_SEL] = st_reg.calendar_second_select;
      end else if (rd_alarm) begin
         st_next.rdata = st_reg.alarm_value;
      end else if (rd_value) begin
         st_next.rdata = st_reg.counter_value;
      end else if (rd_status) begin
         st_next.rdata[SCT_STAT_ALARM] = st_reg.alarm_flag;
         st_next.rdata[SCT_STAT_INC] = st_reg.increment_flag;
      end
   end

   // State register with synchronous reset.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st_reg <= '0;
         st_reg.divisor <= SCT_DIV_RESET;
         st_reg.alarm_value <= SCT_ALARM_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs driven straight from the state register.
   assign rdata = st_reg.rdata;
   assign alarm_out = st_reg.alarm_flag;
   assign irq = (st_reg.irq_hold == 2'h0) &&
                ((st_reg.alarm_flag && st_reg.alarm_irq_enable) ||
                 (st_reg.increment_flag && st_reg.increment_irq_enable));

endmodule

/* File: sct_timer_monitor.sv */
// Checker for the timer's register port, flags and interrupt.
// Assumes it is bound to sct_timer and sees its ports only.
`timescale 1ns/1ps
module sct_timer_monitor
   import sct_pkg::*;
(
   // Watched ports.
   input wire logic ref_clk,
   input wire logic resetn,
   input wire sct_bus_req_s bus_req,
   input wire logic [31:0] rdata,
   input wire logic irq,
   input wire logic alarm_out
);
   // Checks run on ref_clk and rest during reset.
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // Decoded status and mode reads.
   wire logic rd_st = bus_req.rd && bus_req.addr == SCT_OFS_STATUS;
   wire logic rd_md = bus_req.rd && bus_req.addr == SCT_OFS_MODE;
   // Restart write followed by a value read.
   sequence s_restart;
      bus_req.wr && bus_req.addr == SCT_OFS_MODE && bus_req.wdata[SCT_MODE_RESTART];
   endsequence
   sequence s_rd_value;
      bus_req.rd && bus_req.addr == SCT_OFS_VALUE;
   endsequence
   property p_restart;
      s_restart ##2 s_rd_value |=> rdata == 32'h00000000;
   endproperty
   a_restart: assert property (p_restart) else $error("count not cleared");
   property p_rd_idle;
      !$past(bus_req.rd) |-> rdata == 32'h00000000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("data outside slot");
   property p_mode_restart;
      rd_md |=> rdata[SCT_MODE_RESTART] == 1'b0;
   endproperty
   a_mode_restart: assert property (p_mode_restart) else $error("restart bit read");
   property p_stat_high;
      rd_st |=> rdata[31:2] == 30'h00000000;
   endproperty
   a_stat_high: assert property (p_stat_high) else $error("status upper bits");
   property p_stat_alarm;
      rd_st |=> rdata[SCT_STAT_ALARM] == $past(alarm_out);
   endproperty
   a_stat_alarm: assert property (p_stat_alarm) else $error("alarm bit wrong");
   property p_alarm_fall;
      $fell(alarm_out) |-> $past(rd_st);
   endproperty
   a_alarm_fall: assert property (p_alarm_fall) else $error("alarm cleared");
   property p_alarm_hold;
      alarm_out && !rd_st |=> alarm_out;
   endproperty
   a_alarm_hold: assert property (p_alarm_hold) else $error("alarm lost");
   property p_irq_hold;
      rd_st |=> !irq [*3];
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq too soon");
endmodule
bind sct_timer sct_timer_monitor u_mon (.ref_clk(ref_clk), .resetn(resetn),
   .bus_req(bus_req), .rdata(rdata), .irq(irq), .alarm_out(alarm_out));

/* File: testbench.sv */
// Self-checking bench for the timer: register accesses, slow and calendar
// edges. Assumes the checker binds itself to the timer.
`timescale 1ns/1ps
module testbench;
   import sct_pkg::*;
   // Mode bit masks.
   localparam logic [31:0] RST = 32'h1 << SCT_MODE_RESTART;
   localparam logic [31:0] AIE = 32'h1 << SCT_MODE_ALM_IEN;
   localparam logic [31:0] IIE = 32'h1 << SCT_MODE_INC_IEN;
   localparam logic [31:0] DIS = 32'h1 << SCT_MODE_DISABLE;
   localparam logic [31:0] CAL = 32'h1 << SCT_MODE_CAL_SEL;
   // Stimulus, responses and counters.
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   sct_bus_req_s bus_req = '0;
   logic [31:0] rdata;
   logic slow_clock = 1'b0;
   logic calendar_tick = 1'b0;
   logic irq;
   logic alarm_out;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int seed = 32'h1c5c977d;
   int div;
   int n;
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
   $display("MISMATCH %0t got %h exp %h", $time, (a), (e)); end end
   // The 20 MHz clock.
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end
   sct_timer DUT (.ref_clk(ref_clk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
      .slow_clock(slow_clock), .calendar_tick(calendar_tick), .irq(irq),
      .alarm_out(alarm_out));
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Cuts a hung run short.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         stop_test();
      end
   end
   // One access; a read checks its data in the one-cycle slot.
   // The request is driven at one edge and sampled at the next; read data
   // stand for one cycle after that edge, so they are checked just past it.
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge ref_clk);
      bus_req <= '0;
      #1;
      if (!w) `CHK(rdata, d)
   endtask
   // Slow or calendar edges, each level held five cycles.
   task automatic pulse(input int k, input logic cal);
      repeat (k) begin
         slow_clock <= !cal;
         calendar_tick <= cal;
         repeat (5) @(posedge ref_clk);
         slow_clock <= 1'b0;
         calendar_tick <= 1'b0;
         repeat (5) @(posedge ref_clk);
      end
      #1;
   endtask
   // Expected count after k slow edges at divisor dv.
   function automatic logic [31:0] cnt(input int k, input int dv);
      return 32'(k / dv);
   endfunction
   // Main sequence.
   initial begin
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      acc(0, SCT_OFS_MODE, {16'h0000, SCT_DIV_RESET});
      acc(0, SCT_OFS_ALARM, SCT_ALARM_RESET);
      acc(1, SCT_OFS_VALUE, 32'h00000005);
      acc(0, SCT_OFS_VALUE, 32'h00000000);
      acc(0, SCT_OFS_STATUS, 32'h00000000);
      acc(0, 8'h10, 32'h00000000);
      repeat (3) begin
         div = 3 + ($random(seed) & 3);
         n = div + ($random(seed) & 7);
         acc(1, SCT_OFS_MODE, 32'(div) | RST);
         acc(0, SCT_OFS_VALUE, 32'h00000000);
         pulse(n, 1'b0);
         acc(0, SCT_OFS_VALUE, cnt(n, div));
         acc(0, SCT_OFS_VALUE, cnt(n, div));
         acc(0, SCT_OFS_STATUS, 32'h00000002);
         acc(0, SCT_OFS_STATUS, 32'h00000000);
      end
      acc(1, SCT_OFS_ALARM, 32'h00000002);
      acc(0, SCT_OFS_ALARM, 32'h00000002);
      acc(1, SCT_OFS_MODE, 32'h3 | RST | AIE);
      pulse(6, 1'b0);
      `CHK(alarm_out, 1'b1)
      `CHK(irq, 1'b1)
      acc(0, SCT_OFS_STATUS, 32'h00000003);
      `CHK(alarm_out, 1'b0)
      acc(1, SCT_OFS_MODE, 32'h3 | IIE);
      pulse(3, 1'b0);
      `CHK(irq, 1'b1)
      acc(1, SCT_OFS_MODE, 32'h00000003);
      `CHK(irq, 1'b0)
      acc(1, SCT_OFS_MODE, 32'h3 | RST | DIS);
      `CHK(irq, 1'b0)
      pulse(6, 1'b0);
      acc(0, SCT_OFS_VALUE, 32'h00000000);
      acc(1, SCT_OFS_MODE, 32'h00000003);
      pulse(3, 1'b0);
      acc(0, SCT_OFS_VALUE, 32'h00000001);
      acc(1, SCT_OFS_MODE, 32'h3 | RST | CAL);
      pulse(3, 1'b0);
      acc(0, SCT_OFS_VALUE, 32'h00000000);
      acc(0, SCT_OFS_STATUS, 32'h00000002);
      pulse(2, 1'b1);
      acc(0, SCT_OFS_VALUE, 32'h00000002);
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      acc(0, SCT_OFS_MODE, {16'h0000, SCT_DIV_RESET});
      stop_test();
   end
endmodule
